// ==== p1pc_pkg.sv ====
// Constants, types and register map for the port 1 pin control block
// Overview of operation
// - Direction bit 1 makes its pin an output, 0 makes it an input.
// - Direction and latch bits drive a pin only while it is general I/O; direction 1 still blocks the pull-up on interrupt inputs.
// - Reset clears every direction bit, so all pins start as inputs.
// - Direction register is write-only and always reads as all ones.
// - Pull-up on only with direction 0 and enable 1; outputs never pulled.
// - Reset clears the pull-up enable register, all pull-ups off.
// - Reset loads function select with 04: general I/O, fixed pattern.
// - Select bit 7 makes pin 7 the interrupt c and trigger input.
// - Select bits 6 and 5 make pins 6, 5 interrupt inputs b and a.
// - Select bit 4 makes pin 4 drive the pulse-width output.
// - Select bit 0 makes pin 0 drive the timer clock output.
// - Select bits 3 and 1 read 0, bit 2 reads 1, writes ignored.
// - Pins 3 to 1 follow only their own direction bits.
// - Pins float in reset and standby, hold in sleep, subsleep and watch, else run.
// - In standby a pin with pull-up on shows a high level.
// - Interrupt inputs sense rising or falling; trigger also both edges.
// - Port read gives latch for pins with direction bit 1, pin level for the rest, whatever the select bits.
package p1pc_pkg;

   localparam int ADDR_W = 8;
   localparam int PORT_W = 8;

   // Register byte addresses
   localparam logic [7:0] OFS_LATCH = 8'h00;
   localparam logic [7:0] OFS_DIR   = 8'h04;
   localparam logic [7:0] OFS_PUE   = 8'h08;
   localparam logic [7:0] OFS_FSEL  = 8'h0C;
   localparam logic [7:0] OFS_EDGE  = 8'h10;
   localparam logic [7:0] OFS_MODE  = 8'h14;

   // Reset values and fixed fields
   localparam logic [7:0] RST_LATCH  = 8'h00;
   localparam logic [7:0] RST_DIR    = 8'h00;
   localparam logic [7:0] RST_PUE    = 8'h00;
   localparam logic [7:0] RST_FSEL   = 8'h04;
   localparam logic [7:0] FSEL_WMASK = 8'hF1;
   localparam logic [7:0] FSEL_FIXED = 8'h04;
   localparam logic [7:0] DIR_RDVAL  = 8'hFF;
   localparam logic [4:0] RST_EDGE   = 5'h00;

   // Function select and edge field positions
   localparam int FS_IRQC = 7;
   localparam int FS_IRQB = 6;
   localparam int FS_IRQA = 5;
   localparam int FS_PWM  = 4;
   localparam int FS_TMO  = 0;
   localparam int EG_TRIG = 3;

   // Trigger edge modes
   localparam logic [1:0] TRG_FALL = 2'h0;
   localparam logic [1:0] TRG_RISE = 2'h1;

   // Operating mode codes
   localparam logic [2:0] MD_ACTIVE = 3'h0;
   localparam logic [2:0] MD_SUBACT = 3'h1;
   localparam logic [2:0] MD_SLEEP  = 3'h2;
   localparam logic [2:0] MD_SUBSLP = 3'h3;
   localparam logic [2:0] MD_WATCH  = 3'h4;
   localparam logic [2:0] MD_STBY   = 3'h5;
   localparam logic [2:0] RST_MODE  = 3'h0;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pu;
   } p1pc_pins_s;

endpackage

// ==== p1pc_port.sv ====
// Port 1 pin control with APB register access
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module p1pc_port (
   // Clock and reset
   input  wire logic                          CLK,
   input  wire logic                          SRST,
   // APB slave
   input  wire logic                          PSEL,
   input  wire logic                          PENABLE,
   input  wire logic                          PWRITE,
   input  wire logic [p1pc_pkg::ADDR_W-1:0]   PADDR,
   input  wire logic [31:0]                   PWDATA,
   input  wire logic [3:0]                    PSTRB,
   output logic      [31:0]                   PRDATA,
   output logic                               PREADY,
   output logic                               PSLVERR,
   // Pins
   input  wire logic [p1pc_pkg::PORT_W-1:0]   PIN_IN,
   output p1pc_pkg::p1pc_pins_s               PINS,
   // Alternate functions
   input  wire logic                          PWM_IN,
   input  wire logic                          TMR_CLK_IN,
   output logic      [2:0]                    IRQ_EV,
   output logic                               TRIG_EV
);

   function automatic logic is_run(input logic [2:0] m);
      is_run = (m == p1pc_pkg::MD_ACTIVE) || (m == p1pc_pkg::MD_SUBACT)
               || (m > p1pc_pkg::MD_STBY);
   endfunction

   function automatic logic is_stby(input logic [2:0] m);
      is_stby = (m == p1pc_pkg::MD_STBY);
   endfunction

   logic [7:0]  latch_q, latch_d;
   logic [7:0]  dir_q, dir_d;
   logic [7:0]  pue_q, pue_d;
   logic [7:0]  fsel_q, fsel_d;
   logic [4:0]  edge_q, edge_d;
   logic [2:0]  mode_q, mode_d;
   logic [31:0] rdata_q, rdata_d;
   logic        err_q, err_d;
   logic [7:0]  fsel_rd;
   logic [7:0]  port_rd;
   logic        wr_en;
   logic        setup;
   logic        hit;

   assign setup  = PSEL & ~PENABLE;
   assign wr_en  = PSEL & PENABLE & PWRITE & PSTRB[0];
   assign PREADY = 1'b1;
   assign PRDATA = rdata_q;
   assign PSLVERR = err_q;

   // Reserved bits forced on read
   assign fsel_rd = (fsel_q & p1pc_pkg::FSEL_WMASK)
                    | p1pc_pkg::FSEL_FIXED;

   // Synchroniser: s1 feeds only s2
   logic [7:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, prev_q;

   assign lvl_d = (s2_q == s3_q) ? s2_q : lvl_q;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         s1_q   <= 8'h00;
         s2_q   <= 8'h00;
         s3_q   <= 8'h00;
         lvl_q  <= 8'h00;
         prev_q <= 8'h00;
      end else begin
         s1_q   <= PIN_IN;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         lvl_q  <= lvl_d;
         prev_q <= lvl_q;
      end
   end

   // Latch bits where the direction bit is 1, filtered level otherwise
   assign port_rd = (latch_q & dir_q) | (lvl_q & ~dir_q);

   always_comb begin
      latch_d = latch_q;
      dir_d   = dir_q;
      pue_d   = pue_q;
      fsel_d  = fsel_q;
      edge_d  = edge_q;
      mode_d  = mode_q;
      if (wr_en) begin
         unique case (PADDR)
            p1pc_pkg::OFS_LATCH: latch_d = PWDATA[7:0];
            p1pc_pkg::OFS_DIR:   dir_d   = PWDATA[7:0];
            p1pc_pkg::OFS_PUE:   pue_d   = PWDATA[7:0];
            p1pc_pkg::OFS_FSEL:  fsel_d  = PWDATA[7:0]
                                 & p1pc_pkg::FSEL_WMASK;
            p1pc_pkg::OFS_EDGE:  edge_d  = PWDATA[4:0];
            p1pc_pkg::OFS_MODE:  mode_d  = PWDATA[2:0];
            default: ;
         endcase
      end
   end

   // Read data staged in setup so the access phase needs no wait
   always_comb begin
      rdata_d = 32'h0000_0000;
      hit     = 1'b1;
      unique case (PADDR)
         p1pc_pkg::OFS_LATCH: rdata_d[7:0] = port_rd;
         p1pc_pkg::OFS_DIR:   rdata_d[7:0] = p1pc_pkg::DIR_RDVAL;
         p1pc_pkg::OFS_PUE:   rdata_d[7:0] = pue_q;
         p1pc_pkg::OFS_FSEL:  rdata_d[7:0] = fsel_rd;
         p1pc_pkg::OFS_EDGE:  rdata_d[4:0] = edge_q;
         p1pc_pkg::OFS_MODE:  rdata_d[2:0] = mode_q;
         default:             hit = 1'b0;
      endcase
      if (!setup) begin
         rdata_d = rdata_q;
      end
      err_d = setup ? ~hit : err_q;
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         latch_q <= p1pc_pkg::RST_LATCH;
         dir_q   <= p1pc_pkg::RST_DIR;
         pue_q   <= p1pc_pkg::RST_PUE;
         fsel_q  <= p1pc_pkg::RST_FSEL;
         edge_q  <= p1pc_pkg::RST_EDGE;
         mode_q  <= p1pc_pkg::RST_MODE;
         rdata_q <= 32'h0000_0000;
         err_q   <= 1'b0;
      end else begin
         latch_q <= latch_d;
         dir_q   <= dir_d;
         pue_q   <= pue_d;
         fsel_q  <= fsel_d;
         edge_q  <= edge_d;
         mode_q  <= mode_d;
         rdata_q <= rdata_d;
         err_q   <= err_d;
      end
   end

   // Pin drive
   logic [7:0] alt_in, alt_out, alt_val;
   logic [7:0] oe_q, oe_d, out_q, out_d, pu_q, pu_d;

   assign alt_in  = {fsel_q[p1pc_pkg::FS_IRQC], fsel_q[p1pc_pkg::FS_IRQB],
                     fsel_q[p1pc_pkg::FS_IRQA], 5'h00};
   assign alt_out = {3'h0, fsel_q[p1pc_pkg::FS_PWM], 3'h0,
                     fsel_q[p1pc_pkg::FS_TMO]};
   assign alt_val = {3'h0, PWM_IN, 3'h0, TMR_CLK_IN};

   always_comb begin
      oe_d  = oe_q;
      out_d = out_q;
      pu_d  = pu_q;
      // Sleep, subsleep and watch freeze the pins
      if (is_run(mode_q) || is_stby(mode_q)) begin
         pu_d  = pue_q & ~dir_q & ~alt_out;
         oe_d  = (dir_q & ~alt_in & ~alt_out) | alt_out;
         out_d = (alt_out & alt_val)
                 | (~alt_out & latch_q);
      end
      if (is_stby(mode_q)) begin
         oe_d = 8'h00;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         oe_q  <= 8'h00;
         out_q <= 8'h00;
         pu_q  <= 8'h00;
      end else begin
         oe_q  <= oe_d;
         out_q <= out_d;
         pu_q  <= pu_d;
      end
   end

   assign PINS.oe  = oe_q;
   assign PINS.out = out_q;
   assign PINS.pu  = pu_q;

   // Edge sensing on the filtered level
   logic [7:0] rise, fall;
   logic [2:0] irq_d, irq_q;
   logic       trg_d, trg_q;

   assign rise = lvl_q & ~prev_q;
   assign fall = ~lvl_q & prev_q;

   always_comb begin
      for (int k = 0; k < 3; k++) begin
         irq_d[k] = alt_in[k+5] & (edge_q[k] ? rise[k+5] : fall[k+5]);
      end
      unique case (edge_q[p1pc_pkg::EG_TRIG +: 2])
         p1pc_pkg::TRG_FALL: trg_d = fall[7];
         p1pc_pkg::TRG_RISE: trg_d = rise[7];
         default:            trg_d = rise[7] | fall[7];
      endcase
      trg_d = trg_d & alt_in[7];
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         irq_q <= 3'h0;
         trg_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
         trg_q <= trg_d;
      end
   end

   assign IRQ_EV  = irq_q;
   assign TRIG_EV = trg_q;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   logic run_m;
   assign run_m = is_run(mode_q);

   dir_reads_ones_a: assert property (
      PSEL && PENABLE && !PWRITE && PADDR == p1pc_pkg::OFS_DIR
      |-> PRDATA == 32'h0000_00FF)
      else $error("direction read not all ones");

   dir_reset_a: assert property (
      $past(SRST) |-> dir_q == 8'h00 && PINS.oe == 8'h00)
      else $error("direction not cleared by reset");

   pue_reset_a: assert property (
      $past(SRST) |-> pue_q == 8'h00 && PINS.pu == 8'h00)
      else $error("pull-up enable not cleared by reset");

   fsel_reset_a: assert property (
      $past(SRST) |-> fsel_rd == 8'h04)
      else $error("function select reset value wrong");

   fsel_fixed_a: assert property (
      PSEL && PENABLE && !PWRITE && PADDR == p1pc_pkg::OFS_FSEL
      |-> PRDATA[3:1] == 3'b010)
      else $error("reserved select bits changed");

   pullup_off_a: assert property (
      run_m && dir_q == 8'hFF |=> PINS.pu == 8'h00)
      else $error("pull-up on an output pin");

   pullup_on_a: assert property (
      run_m && dir_q[2] == 1'b0 && pue_q[2] |=> PINS.pu[2])
      else $error("pull-up missing on input pin");

   alt_input_a: assert property (
      run_m && fsel_q[7:5] == 3'b111 |=> PINS.oe[7:5] == 3'b000)
      else $error("interrupt input pin driven");

   pwm_drive_a: assert property (
      run_m && fsel_q[4]
      |=> PINS.oe[4] && PINS.out[4] == $past(PWM_IN))
      else $error("pulse-width pin not driven");

   tmo_drive_a: assert property (
      run_m && fsel_q[0]
      |=> PINS.oe[0] && PINS.out[0] == $past(TMR_CLK_IN))
      else $error("timer clock pin not driven");

   gpio_out_a: assert property (
      run_m |=> PINS.oe[2] == $past(dir_q[2])
                && PINS.out[2] == $past(latch_q[2]))
      else $error("general pin not following latch");

   standby_float_a: assert property (
      is_stby(mode_q) |=> PINS.oe == 8'h00)
      else $error("pin driven in standby");

   hold_pins_a: assert property (
      !run_m && !is_stby(mode_q) |=> $stable(PINS.oe) && $stable(PINS.out))
      else $error("pins changed in hold mode");

   port_read_a: assert property (
      setup && PADDR == p1pc_pkg::OFS_LATCH
      |=> PRDATA[7:0] == $past(port_rd))
      else $error("port read value wrong");

   irq_rise_a: assert property (
      fsel_q[5] && edge_q[0] && rise[5] |=> IRQ_EV[0])
      else $error("rising edge event missed");

   irq_fall_a: assert property (
      fsel_q[7] && !edge_q[2] && fall[7] |=> IRQ_EV[2])
      else $error("falling edge event missed");

   trig_rise_a: assert property (
      fsel_q[7] && edge_q[p1pc_pkg::EG_TRIG +: 2] == p1pc_pkg::TRG_RISE
      && rise[7] |=> TRIG_EV)
      else $error("trigger rising edge missed");

   // Both-edge mode must catch the fall the rise-only mode ignores
   trig_both_a: assert property (
      fsel_q[7] && edge_q[p1pc_pkg::EG_TRIG + 1] && fall[7] |=> TRIG_EV)
      else $error("trigger both-edge event missed");

   cov_alt_c: cover property (fsel_q[7] ##1 TRIG_EV);
   cov_stby_c: cover property (is_stby(mode_q) && PINS.pu != 8'h00);
   cov_wr_c: cover property (wr_en && PADDR == p1pc_pkg::OFS_DIR);
   cov_err_c: cover property (PSLVERR && PENABLE);

endmodule

// ==== p1pc_board.sv ====
// Board model that resolves the port pin levels
`timescale 1ns/10ps
module p1pc_board (
   // Clock
   input  wire logic            CLK,
   // Port side and board drivers
   input  p1pc_pkg::p1pc_pins_s pins,
   input  wire logic [7:0]      ext_val,
   input  wire logic [7:0]      ext_en,
   // Level seen by the port
   output logic      [7:0]      pin_lvl
);
   logic [7:0] float_q = 8'h00;
   // Floating pins toggle every clock, so the port filter holds its last level
   always_ff @(posedge CLK) begin
      float_q <= ~float_q;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pins.oe[i])
            pin_lvl[i] = pins.out[i];
         else if (ext_en[i])
            pin_lvl[i] = ext_val[i];
         else if (pins.pu[i])
            pin_lvl[i] = 1'b1;
         else
            pin_lvl[i] = float_q[i];
      end
   end
endmodule

// ==== port1_pin_control_test.sv ====
// Self-checking bench for the port 1 pin control block
`timescale 1ns/10ps
module port1_pin_control_test;
   logic                 clk = 1'b0;
   logic                 srst = 1'b1;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic [7:0]           paddr = 8'h00;
   logic [31:0]          pwdata = 32'h0;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic [7:0]           pin_in;
   p1pc_pkg::p1pc_pins_s pins;
   logic                 pwm_in = 1'b0;
   logic                 tmr_in = 1'b0;
   logic [2:0]           irq_ev;
   logic                 trig_ev;
   logic [7:0]           ext_val = 8'h00;
   logic [7:0]           ext_en = 8'h00;
   logic [31:0]          rd;
   logic                 er;
   int                   mismatches = 0;
   int                   n_checks = 0;

   p1pc_port dut (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .PIN_IN(pin_in), .PINS(pins), .PWM_IN(pwm_in),
      .TMR_CLK_IN(tmr_in), .IRQ_EV(irq_ev), .TRIG_EV(trig_ev));
   p1pc_board board (.CLK(clk), .pins(pins), .ext_val(ext_val),
      .ext_en(ext_en), .pin_lvl(pin_in));

   initial begin
      forever #25 clk = ~clk;
   end

   task automatic stop_test;
      if (mismatches == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One APB transfer, entered just after a rising edge
   task automatic apb(input int wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr[0];
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         stop_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Pulse wait, bounded; index 3 is the trigger
   task automatic ev(input int b, input string nm);
      logic s;
      s = 1'b0;
      for (int n = 0; n < 12 && !s; n++) begin
         @(negedge clk);
         s = (b == 3) ? trig_ev : irq_ev[b];
      end
      @(posedge clk);
      chk(nm, 32'h1, {31'h0, s});
   endtask

   initial begin
      tick(20);
      srst <= 1'b0;
      @(posedge clk);
      chk("oe", 32'h0, {24'h0, pins.oe});
      chk("pu", 32'h0, {24'h0, pins.pu});
      apb(0, p1pc_pkg::OFS_FSEL, 0);
      chk("fsel", 32'h04, rd);
      apb(0, p1pc_pkg::OFS_PUE, 0);
      chk("pue", 32'h0, rd);
      apb(1, p1pc_pkg::OFS_DIR, 32'h0F);
      apb(0, p1pc_pkg::OFS_DIR, 0);
      chk("dir", 32'hFF, rd);
      apb(1, p1pc_pkg::OFS_LATCH, 32'hA5);
      tick(2);
      chk("oe", 32'h0F, {24'h0, pins.oe});
      chk("out", 32'h5, {28'h0, pins.out[3:0]});
      apb(1, p1pc_pkg::OFS_PUE, 32'hFF);
      tick(2);
      chk("pu", 32'hF0, {24'h0, pins.pu});
      ext_en <= 8'hF0;
      ext_val <= 8'h30;
      tick(8);
      apb(0, p1pc_pkg::OFS_LATCH, 0);
      chk("port", 32'h35, rd);
      apb(1, p1pc_pkg::OFS_FSEL, 32'hFF);
      apb(0, p1pc_pkg::OFS_FSEL, 0);
      chk("fsel", 32'hF5, rd);
      // Source levels opposite to the latch bits
      pwm_in <= 1'b1;
      apb(1, p1pc_pkg::OFS_FSEL, 32'h11);
      tick(3);
      chk("oe", 32'h1F, {24'h0, pins.oe});
      chk("alt", 32'h2, {30'h0, pins.out[4], pins.out[0]});
      chk("pu", 32'hE0, {24'h0, pins.pu});
      apb(1, p1pc_pkg::OFS_FSEL, 32'hE0);
      apb(1, p1pc_pkg::OFS_DIR, 32'hFF);
      apb(1, p1pc_pkg::OFS_EDGE, 32'h07);
      tick(2);
      chk("oe", 32'h1F, {24'h0, pins.oe});
      ext_val <= 8'h00;
      tick(8);
      for (int i = 0; i < 3; i++) begin
         ext_val[5+i] <= 1'b1;
         ev(i, "irq");
      end
      ext_val[7] <= 1'b0;
      ev(3, "trig fall");
      apb(1, p1pc_pkg::OFS_EDGE, 32'h08);
      ext_val[7] <= 1'b1;
      ev(3, "trig rise");
      apb(1, p1pc_pkg::OFS_EDGE, 32'h10);
      ext_val[7] <= 1'b0;
      ev(3, "trig both");
      apb(1, p1pc_pkg::OFS_DIR, 32'h00);
      apb(1, p1pc_pkg::OFS_MODE, 32'h5);
      tick(3);
      chk("stby oe", 32'h0, {24'h0, pins.oe});
      chk("stby pu", 32'hFF, {24'h0, pins.pu});
      // Pulled-up inputs read high, board drives 7:4
      apb(0, p1pc_pkg::OFS_LATCH, 0);
      chk("stby pin", 32'h6F, rd);
      apb(1, p1pc_pkg::OFS_MODE, 32'h0);
      apb(1, p1pc_pkg::OFS_DIR, 32'h0F);
      apb(1, p1pc_pkg::OFS_MODE, 32'h2);
      apb(1, p1pc_pkg::OFS_LATCH, 32'h0A);
      tick(3);
      chk("hold", 32'h5, {28'h0, pins.out[3:0]});
      apb(1, p1pc_pkg::OFS_MODE, 32'h0);
      tick(3);
      chk("run", 32'hA, {28'h0, pins.out[3:0]});
      apb(0, 8'h20, 0);
      chk("unmapped err", 32'h1, {31'h0, er});
      chk("unmapped rd", 32'h0, rd);
      stop_test();
   end
endmodule
